// [verilog/dacwu_pkg.sv]
// Package: constants, register map and carrier types of the DAC waveform update control
package dacwu_pkg;
  // Clock rates in MHz; the 40 MHz base clock is a fractional enable from the 125 MHz system clock
  localparam int unsigned DACWU_SYS_MHZ  = 125;
  localparam int unsigned DACWU_BASE_MHZ = 40;
  localparam logic [7:0]  DIV_STEP       = 8'(DACWU_BASE_MHZ);
  localparam logic [7:0]  DIV_MOD        = 8'(DACWU_SYS_MHZ);
  // Widths and depths
  localparam int unsigned CODE_W    = 12;
  localparam int unsigned CNT_W     = 24;
  localparam int unsigned DLY_W     = 16;
  localparam int unsigned BUF_DEPTH = 512;
  localparam int unsigned BUF_AW    = 9;
  localparam int unsigned LEN_W     = 10;
  localparam logic [LEN_W-1:0] BUF_FULL = 10'h200;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_UI     = 8'h0C;
  localparam logic [7:0] REG_UC     = 8'h10;
  localparam logic [7:0] REG_IC     = 8'h14;
  localparam logic [7:0] REG_DLY1   = 8'h18;
  localparam logic [7:0] REG_DLY2   = 8'h1C;
  localparam logic [7:0] REG_DATA0  = 8'h20;
  localparam logic [7:0] REG_DATA1  = 8'h24;
  localparam logic [7:0] REG_FIFO0  = 8'h28;
  localparam logic [7:0] REG_FIFO1  = 8'h2C;
  // Control register fields; per-channel fields add the channel number
  localparam int unsigned F_TIMED   = 0;
  localparam int unsigned F_BIPOLAR = 2;
  localparam int unsigned F_EXTREF  = 4;
  localparam int unsigned F_TRIGEXT = 6;
  localparam int unsigned F_DLYEN   = 7;
  localparam int unsigned F_DLYUPD  = 8;
  localparam int unsigned F_GAPUPD  = 9;
  localparam int unsigned F_INFIN   = 10;
  localparam int unsigned F_RETRIG  = 11;
  localparam int unsigned F_STOPM   = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3FFF;
  // Command register fields
  localparam int unsigned C_ARM = 0;
  localparam int unsigned C_TRIG = 1;
  localparam int unsigned C_STOP = 2;
  localparam int unsigned C_CLR  = 3;
  // Status register fields
  localparam int unsigned S_LEN0 = 8;
  localparam int unsigned S_LEN1 = 18;
  // Values after reset
  localparam logic [31:0]       CTRL_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  UI_RST   = 24'h00_0028;
  localparam logic [CNT_W-1:0]  UC_RST   = 24'h00_0001;
  localparam logic [CNT_W-1:0]  IC_RST   = 24'h00_0001;
  localparam logic [DLY_W-1:0]  DLY_RST  = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  // Stop modes
  localparam logic [1:0] STOP_NOW = 2'h1;
  localparam logic [1:0] STOP_WAVE = 2'h2;
  localparam logic [1:0] STOP_ITER = 2'h3;
  // Timing engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_WAIT = 5'h02, ST_DELAY = 5'h04, ST_RUN = 5'h08, ST_GAP = 5'h10
  } dacwu_state_t;
  // Timing configuration handed to the engine
  typedef struct packed {
    logic [CNT_W-1:0] ui;
    logic [CNT_W-1:0] uc;
    logic [CNT_W-1:0] ic;
    logic [DLY_W-1:0] dly1;
    logic [DLY_W-1:0] dly2;
    logic             dly_en;
    logic             dly_upd;
    logic             gap_upd;
    logic             infinite;
    logic             retrig;
    logic [1:0]       stop_mode;
  } dacwu_cfg_t;
  // Signals toward one converter channel
  typedef struct packed {
    logic              sel_external_reference_input;
    logic              bipolar;
    logic              converter_update_strobe;
    logic [CODE_W-1:0] code;
  } dacwu_chan_t;
endpackage : dacwu_pkg

// [verilog/dacwu_engine.sv]
// Timing engine: trigger wait, delay, update pacing, iterations, gaps and stop modes
`timescale 1ns/1ps
module dacwu_engine
  import dacwu_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Pacing and commands
  input  wire logic       base_tick,
  input  wire dacwu_cfg_t cfg,
  input  wire logic       arm,
  input  wire logic       trig,
  input  wire logic       stop,
  // State and events
  output logic            busy,
  output logic            waiting,
  output logic            stop_pending,
  output logic            update,
  output logic            wave_start
);
  dacwu_state_t     state;
  logic [CNT_W-1:0] ui_cnt;
  logic [CNT_W-1:0] uc_cnt;
  logic [CNT_W-1:0] iter_cnt;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] next_iter;
  logic [DLY_W-1:0] dly_cnt;
  logic             per_tick;
  logic             dly_step;
  logic             ui_expire;
  logic             wave_end;
  logic             cycle_done;
  logic             stop_now;
  logic             end_stop;

  // Decode of the current step
  always_comb begin
    per_tick   = base_tick && (per_cnt <= 24'h00_0001);
    dly_step   = ((state == ST_GAP) ? cfg.gap_upd : cfg.dly_upd) ? per_tick : base_tick;
    ui_expire  = (state == ST_RUN) && base_tick && (ui_cnt <= 24'h00_0001);
    wave_end   = ui_expire && (uc_cnt <= 24'h00_0001);
    next_iter  = iter_cnt + 24'h00_0001;
    cycle_done = next_iter >= cfg.ic;
    stop_now   = stop && (cfg.stop_mode != STOP_WAVE) && (cfg.stop_mode != STOP_ITER);
    end_stop   = stop_pending && ((cfg.stop_mode == STOP_WAVE) || cycle_done);
    busy       = (state != ST_IDLE);
    waiting    = (state == ST_WAIT);
  end

  // Update-period clock for the delay counters
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) per_cnt <= UI_RST;
    else if (state == ST_WAIT || wave_end) per_cnt <= cfg.ui;
    else if (base_tick) per_cnt <= per_tick ? cfg.ui : per_cnt - 24'h00_0001;
  end

  // Deferred stop request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) stop_pending <= 1'b0;
    else if (stop && busy) stop_pending <= 1'b1;
    else if (!busy) stop_pending <= 1'b0;
  end

  // Sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      ui_cnt     <= UI_RST;
      uc_cnt     <= UC_RST;
      iter_cnt   <= '0;
      dly_cnt    <= DLY_RST;
      update     <= 1'b0;
      wave_start <= 1'b0;
    end else begin
      update     <= 1'b0;
      wave_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (arm) state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (stop) state <= ST_IDLE;
          else if (trig) begin
            iter_cnt <= '0;
            if (cfg.dly_en && cfg.dly1 != 16'h0000) begin
              dly_cnt <= cfg.dly1;
              state   <= ST_DELAY;
            end else begin
              ui_cnt     <= cfg.ui;
              uc_cnt     <= cfg.uc;
              wave_start <= 1'b1;
              state      <= ST_RUN;
            end
          end
        end
        ST_DELAY, ST_GAP: begin
          if (stop_now || (state == ST_DELAY && stop) || (stop_pending && cfg.stop_mode == STOP_WAVE)) begin
            state <= ST_IDLE;
          end else if (dly_step) begin
            if (dly_cnt <= 16'h0001) begin
              ui_cnt     <= cfg.ui;
              uc_cnt     <= cfg.uc;
              wave_start <= 1'b1;
              state      <= ST_RUN;
            end else dly_cnt <= dly_cnt - 16'h0001;
          end
        end
        ST_RUN: begin
          if (stop_now) state <= ST_IDLE;
          else if (ui_expire) begin
            update <= 1'b1;
            ui_cnt <= cfg.ui;
            if (wave_end) begin
              iter_cnt <= cycle_done ? '0 : next_iter;
              uc_cnt   <= cfg.uc;
              if (end_stop) state <= ST_IDLE;
              else if (!cfg.infinite && cycle_done) begin
                state <= (cfg.retrig && !stop_pending) ? ST_WAIT : ST_IDLE;
              end else if (cfg.dly2 != 16'h0000) begin
                dly_cnt <= cfg.dly2;
                state   <= ST_GAP;
              end else wave_start <= 1'b1;
            end else uc_cnt <= uc_cnt - 24'h00_0001;
          end else if (base_tick) ui_cnt <= ui_cnt - 24'h00_0001;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : dacwu_engine

// [verilog/dacwu_top.sv]
// Top: Wishbone registers, sample buffers and converter outputs of the DAC waveform update control
`timescale 1ns/1ps
module dacwu_top
  import dacwu_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // Wishbone classic slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // External digital trigger
  input  wire logic         ext_trig,
  // Converter channels
  output dacwu_chan_t [1:0] dac_out
);

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] apply_sel(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[8*b +: 8] = new_val[8*b +: 8];
    end
    return res;
  endfunction : apply_sel

  // Next read index of a sample buffer, wrapping at the stored length
  function automatic logic [BUF_AW-1:0] wrap_inc(input logic [BUF_AW-1:0] idx,
                                                 input logic [LEN_W-1:0]  len);
    logic [LEN_W-1:0] nxt;
    nxt = {1'b0, idx} + 10'h001;
    return (nxt >= len) ? '0 : nxt[BUF_AW-1:0];
  endfunction : wrap_inc

  // Registers
  logic [31:0]       ctrl;
  logic [CNT_W-1:0]  ui_reg;
  logic [CNT_W-1:0]  uc_reg;
  logic [CNT_W-1:0]  ic_reg;
  logic [DLY_W-1:0]  dly1_reg;
  logic [DLY_W-1:0]  dly2_reg;
  // Sample buffers
  logic [CODE_W-1:0] buf_mem [2][BUF_DEPTH];
  logic [LEN_W-1:0]  buf_len [2];
  logic [BUF_AW-1:0] rd_idx  [2];
  // Bus decode
  logic              req;
  logic              wr_en;
  logic              hit_ctrl;
  logic              hit_cmd;
  logic              hit_ui;
  logic              hit_uc;
  logic              hit_ic;
  logic              hit_dly1;
  logic              hit_dly2;
  logic [1:0]        hit_data;
  logic [1:0]        hit_fifo;
  logic [31:0]       rd_data;
  logic [31:0]       w_ctrl;
  logic [31:0]       w_ui;
  logic [31:0]       w_uc;
  logic [31:0]       w_ic;
  logic [31:0]       w_dly1;
  logic [31:0]       w_dly2;
  logic [31:0]       w_data [2];
  logic [31:0]       w_fifo;
  // Command pulses and pacing
  logic              cmd_arm;
  logic              cmd_trig;
  logic              cmd_stop;
  logic [1:0]        cmd_clr;
  logic [7:0]        div_acc;
  logic              base_tick;
  logic              ext_trig_q;
  logic              trig;
  logic [1:0]        load_q;
  dacwu_cfg_t        cfg;
  // Engine outputs
  logic              busy;
  logic              waiting;
  logic              stop_pending;
  logic              update;
  logic              wave_start;

  // Bus request and address decode
  always_comb begin
    req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr_en    = req && wb_we_i;
    hit_ctrl = 1'b0;
    hit_cmd  = 1'b0;
    hit_ui   = 1'b0;
    hit_uc   = 1'b0;
    hit_ic   = 1'b0;
    hit_dly1 = 1'b0;
    hit_dly2 = 1'b0;
    hit_data = 2'h0;
    hit_fifo = 2'h0;
    rd_data  = 32'h0000_0000;
    if (wb_adr_i == REG_CTRL) begin
      hit_ctrl = 1'b1;
      rd_data  = ctrl;
    end else if (wb_adr_i == REG_CMD) begin
      hit_cmd = 1'b1;
    end else if (wb_adr_i == REG_STATUS) begin
      rd_data[0]                = busy;
      rd_data[1]                = waiting;
      rd_data[2]                = stop_pending;
      rd_data[S_LEN0 +: LEN_W]  = buf_len[0];
      rd_data[S_LEN1 +: LEN_W]  = buf_len[1];
    end else if (wb_adr_i == REG_UI) begin
      hit_ui  = 1'b1;
      rd_data = {8'h00, ui_reg};
    end else if (wb_adr_i == REG_UC) begin
      hit_uc  = 1'b1;
      rd_data = {8'h00, uc_reg};
    end else if (wb_adr_i == REG_IC) begin
      hit_ic  = 1'b1;
      rd_data = {8'h00, ic_reg};
    end else if (wb_adr_i == REG_DLY1) begin
      hit_dly1 = 1'b1;
      rd_data  = {16'h0000, dly1_reg};
    end else if (wb_adr_i == REG_DLY2) begin
      hit_dly2 = 1'b1;
      rd_data  = {16'h0000, dly2_reg};
    end else if (wb_adr_i == REG_DATA0) begin
      hit_data[0] = 1'b1;
      rd_data     = {20'h0_0000, dac_out[0].code};
    end else if (wb_adr_i == REG_DATA1) begin
      hit_data[1] = 1'b1;
      rd_data     = {20'h0_0000, dac_out[1].code};
    end else if (wb_adr_i == REG_FIFO0) begin
      hit_fifo[0] = 1'b1;
    end else if (wb_adr_i == REG_FIFO1) begin
      hit_fifo[1] = 1'b1;
    end
  end

  // Write data merged under byte enables
  always_comb begin
    w_ctrl    = apply_sel(ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
    w_ui      = apply_sel({8'h00, ui_reg}, wb_dat_i, wb_sel_i);
    w_uc      = apply_sel({8'h00, uc_reg}, wb_dat_i, wb_sel_i);
    w_ic      = apply_sel({8'h00, ic_reg}, wb_dat_i, wb_sel_i);
    w_dly1    = apply_sel({16'h0000, dly1_reg}, wb_dat_i, wb_sel_i);
    w_dly2    = apply_sel({16'h0000, dly2_reg}, wb_dat_i, wb_sel_i);
    w_data[0] = apply_sel({20'h0_0000, dac_out[0].code}, wb_dat_i, wb_sel_i);
    w_data[1] = apply_sel({20'h0_0000, dac_out[1].code}, wb_dat_i, wb_sel_i);
    w_fifo    = apply_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
  end

  // Bus answer: one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) wb_dat_o <= rd_data;
    end
  end

  // Configuration and timing registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= CTRL_RST;
      ui_reg   <= UI_RST;
      uc_reg   <= UC_RST;
      ic_reg   <= IC_RST;
      dly1_reg <= DLY_RST;
      dly2_reg <= DLY_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl <= w_ctrl;
      if (hit_ui)   ui_reg <= w_ui[23:0];
      if (hit_uc)   uc_reg <= w_uc[23:0];
      if (hit_ic)   ic_reg <= w_ic[23:0];
      if (hit_dly1) dly1_reg <= w_dly1[15:0];
      if (hit_dly2) dly2_reg <= w_dly2[15:0];
    end
  end

  // One-cycle command pulses from the command register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_arm  <= 1'b0;
      cmd_trig <= 1'b0;
      cmd_stop <= 1'b0;
      cmd_clr  <= 2'h0;
    end else begin
      cmd_arm  <= wr_en && hit_cmd && wb_sel_i[0] && wb_dat_i[C_ARM];
      cmd_trig <= wr_en && hit_cmd && wb_sel_i[0] && wb_dat_i[C_TRIG];
      cmd_stop <= wr_en && hit_cmd && wb_sel_i[0] && wb_dat_i[C_STOP];
      cmd_clr  <= (wr_en && hit_cmd && wb_sel_i[0]) ? wb_dat_i[C_CLR +: 2] : 2'h0;
    end
  end

  // Fractional divider: 40 enables in every 125 system cycles
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_acc   <= 8'h00;
      base_tick <= 1'b0;
    end else if (div_acc + DIV_STEP >= DIV_MOD) begin
      div_acc   <= div_acc + DIV_STEP - DIV_MOD;
      base_tick <= 1'b1;
    end else begin
      div_acc   <= div_acc + DIV_STEP;
      base_tick <= 1'b0;
    end
  end

  // Trigger edge on the external input
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) ext_trig_q <= 1'b0;
    else ext_trig_q <= ext_trig;
  end

  // Trigger selection and engine configuration
  always_comb begin
    trig          = ctrl[F_TRIGEXT] ? (ext_trig && !ext_trig_q) : cmd_trig;
    cfg.ui        = ui_reg;
    cfg.uc        = uc_reg;
    cfg.ic        = ic_reg;
    cfg.dly1      = dly1_reg;
    cfg.dly2      = dly2_reg;
    cfg.dly_en    = ctrl[F_DLYEN];
    cfg.dly_upd   = ctrl[F_DLYUPD];
    cfg.gap_upd   = ctrl[F_GAPUPD];
    cfg.infinite  = ctrl[F_INFIN];
    cfg.retrig    = ctrl[F_RETRIG];
    cfg.stop_mode = ctrl[F_STOPM +: 2];
  end

  // Timing engine shared by the channels in timed mode
  dacwu_engine u_engine (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .base_tick    (base_tick),
    .cfg          (cfg),
    .arm          (cmd_arm),
    .trig         (trig),
    .stop         (cmd_stop),
    .busy         (busy),
    .waiting      (waiting),
    .stop_pending (stop_pending),
    .update       (update),
    .wave_start   (wave_start)
  );

  // Sample buffer fill; words stay stored so each waveform replays them
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      buf_len[0] <= '0;
      buf_len[1] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cmd_clr[c]) buf_len[c] <= '0;
        else if (wr_en && hit_fifo[c] && wb_sel_i[0] && buf_len[c] < BUF_FULL) begin
          buf_len[c] <= buf_len[c] + 10'h001;
        end
      end
    end
  end

  // Sample storage, written at the fill level
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (wr_en && hit_fifo[c] && wb_sel_i[0] && buf_len[c] < BUF_FULL) begin
        buf_mem[c][buf_len[c][BUF_AW-1:0]] <= w_fifo[CODE_W-1:0];
      end
    end
  end

  // Read index: restarts at each waveform, advances per update
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_idx[0] <= '0;
      rd_idx[1] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wave_start || cmd_clr[c]) rd_idx[c] <= '0;
        else if (update && ctrl[F_TIMED + c] && buf_len[c] != '0) rd_idx[c] <= wrap_inc(rd_idx[c], buf_len[c]);
      end
    end
  end

  // Converter outputs: code first, strobe rises the next cycle and falls on a base tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_out <= '0;
      load_q  <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        dac_out[c].bipolar                      <= ctrl[F_BIPOLAR + c];
        dac_out[c].sel_external_reference_input <= ctrl[F_EXTREF + c];
        load_q[c] <= 1'b0;
        if (ctrl[F_TIMED + c]) begin
          if (update && buf_len[c] != '0) begin
            dac_out[c].code <= buf_mem[c][rd_idx[c]];
            load_q[c]       <= 1'b1;
          end
        end else if (wr_en && hit_data[c]) begin
          dac_out[c].code <= w_data[c][11:0];
          load_q[c]       <= 1'b1;
        end
        if (load_q[c]) dac_out[c].converter_update_strobe <= 1'b1;
        else if (base_tick) dac_out[c].converter_update_strobe <= 1'b0;
      end
    end
  end
endmodule : dacwu_top

// [test/dacwu_chk.sv]
// Checker: bus answer and converter output assertions
`timescale 1ns/1ps
module dacwu_chk
  import dacwu_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              resetn,
  // Bus
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Trigger and converters
  input wire logic              ext_trig,
  input wire dacwu_chan_t [1:0] dac_out
);
  logic [31:0] ctrl;
  logic        trg;
  logic        tk;
  logic        wc;
  logic        s0;
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && resetn;
  assign wc = tk && wb_we_i && wb_adr_i == REG_CTRL;
  assign s0 = dac_out[0].converter_update_strobe;
  // Shadow of the control word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) ctrl <= CTRL_RST;
    else if (wc) ctrl <= wb_dat_i;
  end
  // Software trigger seen since reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) trg <= 1'b0;
    else if (tk && wb_we_i && wb_adr_i == REG_CMD && wb_dat_i[C_TRIG]) trg <= 1'b1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ack_answer_a: assert property (tk |=> wb_ack_o)
    else $error("No ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack longer than one cycle");
  code_write_a: assert property (tk && wb_we_i && wb_adr_i == REG_DATA0 && !ctrl[F_TIMED]
    |=> dac_out[0].code == $past(wb_dat_i[11:0])) else $error("Code not written");
  strobe_after_a: assert property (tk && wb_we_i && wb_adr_i == REG_DATA1 && !ctrl[F_TIMED+1]
    |=> ##1 dac_out[1].converter_update_strobe) else $error("No strobe after write");
  strobe_width_a: assert property ($rose(s0) |-> ##[1:5] !s0)
    else $error("Strobe too long");
  code_hold_a: assert property (s0 |-> $stable(dac_out[0].code))
    else $error("Code moved under strobe");
  polarity_cfg_a: assert property (!$past(wc) && !$past(wc, 2) |-> dac_out[0].bipolar == ctrl[F_BIPOLAR]
    && dac_out[1].sel_external_reference_input == ctrl[F_EXTREF+1]) else $error("Config not shown");
  hold_trig_a: assert property (ctrl[F_TIMED] && !trg && !ext_trig |-> !$rose(s0))
    else $error("Update before trigger");
  timed_ignore_a: assert property (tk && wb_we_i && wb_adr_i == REG_DATA0 && ctrl[F_TIMED] && !trg
    |=> $stable(dac_out[0].code)) else $error("Timed channel took write");
endmodule : dacwu_chk
bind dacwu_top dacwu_chk i_dacwu_chk (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_trig(ext_trig), .dac_out(dac_out));

// [test/dacwu_conv_model.sv]
// Partner: converter that latches a code on each strobe rising edge
`timescale 1ns/1ps
module dacwu_conv_model
  import dacwu_pkg::*;
(
  // Converter side
  input wire logic              clk_sys,
  input wire dacwu_chan_t       chan,
  // Observation
  output logic [CODE_W-1:0]     held,
  output int                    n_upd,
  output int                    t_gap,
  output real                   volts
);
  int cyc = 0;
  int t_last = 0;
  // Cycle count for update spacing
  always @(posedge clk_sys) cyc <= cyc + 1;
  initial held = CODE_RST;
  initial n_upd = 0;
  // Latch on the strobe rising edge and convert
  always @(posedge chan.converter_update_strobe) begin
    held = chan.code;
    n_upd = n_upd + 1;
    t_gap = cyc - t_last;
    t_last = cyc;
    if (chan.bipolar) volts = (real'(chan.code) - 2048.0) * 10.0 / 2048.0;
    else volts = real'(chan.code) * 10.0 / 4096.0;
  end
endmodule : dacwu_conv_model

// [test/test_dac_waveform_update_control.sv]
// Testbench: registers, software updates and a timed waveform
`timescale 1ns/1ps
module test_dac_waveform_update_control;
  import dacwu_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic ext_trig = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  dacwu_chan_t [1:0] dac_out;
  logic [11:0] h0, h1;
  int n0, n1, g0, g1;
  int num_errors = 0;
  int cmp_count = 0;
  int tick = 0;
  logic [31:0] q;
  dacwu_top i_dacwu_top (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_trig(ext_trig), .dac_out(dac_out));
  dacwu_conv_model i_dacwu_conv_model_0 (.clk_sys(clk_sys), .chan(dac_out[0]), .held(h0), .n_upd(n0),
    .t_gap(g0), .volts());
  dacwu_conv_model i_dacwu_conv_model_1 (.clk_sys(clk_sys), .chan(dac_out[1]), .held(h1), .n_upd(n1),
    .t_gap(g1), .volts());
  // 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic close_out();
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Reset values and an unmapped read
  task automatic s_reset();
    chk("out", 32'(dac_out), 32'h0);
    bus(1'b0, REG_UI, 32'h0);
    chk("ui", q, 32'(UI_RST));
    bus(1'b0, REG_UC, 32'h0);
    chk("uc", q, 32'(UC_RST));
    bus(1'b0, REG_IC, 32'h0);
    chk("ic", q, 32'(IC_RST));
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : s_reset
  // Boundary codes on both channels with mixed polarity and reference
  task automatic s_sw();
    logic [11:0] c;
    bus(1'b1, REG_CTRL, 32'h24);
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 12'h000 : (i == 1) ? 12'h800 : 12'hFFF;
      bus(1'b1, REG_DATA0, 32'(c));
      bus(1'b1, REG_DATA1, {20'h0_0000, ~c});
      repeat (8) @(posedge clk_sys);
      chk("ch0", 32'(h0), 32'(c));
      chk("ch1", 32'(h1), {20'h0_0000, ~c});
    end
    chk("cfg", {29'h0, dac_out[1].sel_external_reference_input, dac_out[0].bipolar, dac_out[1].bipolar},
      32'h6);
  endtask : s_sw
  // Timed: 3 samples, 2 iterations, software trigger, channel 1 still software
  task automatic s_timed();
    logic [11:0] w[3];
    int k;
    w = '{12'h111, 12'h222, 12'h333};
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_UI, 32'h28);
    foreach (w[i]) bus(1'b1, REG_FIFO0, 32'(w[i]));
    bus(1'b1, REG_UC, 32'h3);
    bus(1'b1, REG_IC, 32'h2);
    bus(1'b1, REG_CMD, 32'h1);
    k = n0;
    bus(1'b1, REG_DATA0, 32'hABC);
    bus(1'b1, REG_DATA1, 32'h555);
    repeat (300) @(posedge clk_sys);
    chk("held", 32'(n0), 32'(k));
    chk("ch1", 32'(h1), 32'h555);
    bus(1'b1, REG_CMD, 32'h2);
    for (int i = 0; i < 6; i++) begin
      while (n0 == k + i) @(posedge clk_sys);
      chk("sample", 32'(h0), 32'(w[i % 3]));
      if (i % 3 != 0) chk("period", 32'(g0 >= 124 && g0 <= 126), 32'h1);
    end
    repeat (1000) @(posedge clk_sys);
    chk("count", 32'(n0), 32'(k + 6));
  endtask : s_timed
  // External trigger edge, endless run, then an immediate stop
  task automatic s_stop();
    int k;
    bus(1'b1, REG_CTRL, 32'h1441);
    bus(1'b1, REG_CMD, 32'h1);
    k = n0;
    ext_trig <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_trig <= 1'b0;
    while (n0 != k + 2) @(posedge clk_sys);
    bus(1'b1, REG_CMD, 32'h4);
    repeat (400) @(posedge clk_sys);
    chk("stopped", 32'(n0), 32'(k + 2));
    bus(1'b0, REG_STATUS, 32'h0);
    chk("idle", {31'h0, q[0]}, 32'h0);
  endtask : s_stop
  // Hang guard
  initial begin
    forever begin
      @(posedge clk_sys);
      tick++;
      if (tick == 20000) begin
        num_errors++;
        close_out();
      end
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    s_reset();
    s_sw();
    s_timed();
    s_stop();
    close_out();
  end
endmodule : test_dac_waveform_update_control
